/* qirc_dev.sv */
// flash-side end: quad i/o read with continuous mode
// --------------------------------------------------------------
// Summary of operation
// [R1] opcode EB, narrow address: three address bytes
// [R2] EB wide or EC: four address bytes
// [R3] address moves four bits per sck
// [R4] read accepted only with quad enable set
// [R5] host keeps sck at or below 104 MHz
// [R6] dummy cycles wait, line values ignored
// [R7] dummy count comes from latency code
// [R8] both latency tables give same counts
// [R9] nibble out per sck, changed on falling
// [R10] any start byte, address steps per byte
// [R11] address wraps to zero, stream continues
// [R12] only upper mode nibble matters
// [R13] upper nibble A: next frame skips opcode
// [R14] other mode: leave continuous at cs rise
// [R15] short frame without instruction leaves continuous
// [R16] two mode cycles follow the address
// [R17] host releases lines by first data falling
// [R18] host tri-states in last mode or dummy
// [R19] host keeps cs low through mode, dummy
// [R20] opcode on line zero, msb first, eight cycles
// [R21] nibbles sampled on rising, high first
// --------------------------------------------------------------
`timescale 1ns/10ps
`include "qirc_params.svh"
module qirc_dev #(
  parameter int AW = 10
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  input  wire logic [7:0]        config_reg_one,
  input  wire logic              wide_address_select,
  input  wire logic              load_we,
  input  wire logic [AW-1:0]     load_addr,
  input  wire logic [7:0]        load_data,
  output qirc_pkg::qirc_dev_st_t phase,
  output logic                   cont_mode,
  qirc_if.dev                    link
);
  import qirc_pkg::*;

  typedef struct packed {
    qirc_dev_st_t  st;
    logic [3:0]    cnt;
    logic [3:0]    nib;
    logic [7:0]    opc;
    logic [31:0]   addr;
    logic [3:0]    mode_hi;
    logic          mode_done;
    logic          pend;
    logic          cont;
    logic          wide;
    logic          hi;
    logic [AW-1:0] ptr;
    logic [3:0]    io_o;
    logic          io_oe;
  } qirc_dev_s_t;

  qirc_dev_s_t s;
  qirc_dev_s_t next_s;
  logic [7:0]  mem [0:(1 << AW) - 1];
  logic [5:0]  pin_q;
  logic [5:0]  pin_rise;
  logic [5:0]  pin_fall;
  logic        cs_rise;
  logic        cs_fall;
  logic        sck_r;
  logic        sck_f;
  logic        cs_low;
  logic [3:0]  io_q;
  logic [7:0]  rd_byte;

  // --------------------------------------------------------------
  // pin sampling
  // --------------------------------------------------------------
  qirc_sync #(
    .W   (6),
    .RST (6'h2f)
  ) u_pins (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       ({link.cs_n, link.sck, link.io}),
    .q       (pin_q),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  assign cs_rise = pin_rise[5];
  assign cs_fall = pin_fall[5];
  assign cs_low  = ~pin_q[5];
  assign sck_r   = pin_rise[4] & cs_low;
  assign sck_f   = pin_fall[4] & cs_low;
  assign io_q    = pin_q[3:0];
  assign rd_byte = mem[s.ptr];

  // one table serves both latency variants
  function automatic logic [3:0] dummy_of(input logic [1:0] lc);
    case (lc)
      2'b00:   dummy_of = `QIRC_DUMMY_LC0;
      2'b01:   dummy_of = `QIRC_DUMMY_LC1;
      2'b10:   dummy_of = `QIRC_DUMMY_LC2;
      default: dummy_of = `QIRC_DUMMY_LC3;
    endcase
  endfunction

  // --------------------------------------------------------------
  // frame sequencing
  // --------------------------------------------------------------
  always_comb begin
    logic [7:0] op;
    logic [3:0] dum;
    op     = {s.opc[6:0], io_q[0]};
    dum    = dummy_of(config_reg_one[`QIRC_LC_LSB +: 2]); // [R7] [R8]
    next_s = s;
    if (cs_rise) begin
      next_s.st    = QD_IDLE;
      next_s.io_oe = 1'b0;
      // no completed mode byte means the frame held no valid read
      next_s.cont  = s.mode_done ? s.pend : 1'b0; // [R14] [R15] [R19]
    end else if (cs_fall) begin
      next_s.cnt       = 4'h0;
      next_s.addr      = 32'h0;
      next_s.mode_done = 1'b0;
      next_s.pend      = 1'b0;
      next_s.io_oe     = 1'b0;
      next_s.nib       = s.wide ? `QIRC_NIB_WIDE : `QIRC_NIB_NARROW;
      next_s.st        = s.cont ? QD_ADDR : QD_OPC; // [R13]
    end else if (sck_r) begin
      case (s.st)
        QD_OPC: begin
          next_s.opc = op; // [R20]
          next_s.cnt = s.cnt + 4'h1;
          if (s.cnt == `QIRC_OP_BITS - 4'h1) begin
            next_s.cnt = 4'h0;
            if (config_reg_one[`QIRC_QE_BIT] && (op == `QIRC_OP_QUAD || op == `QIRC_OP_QUAD_WIDE)) begin // [R4]
              next_s.wide = (op == `QIRC_OP_QUAD_WIDE) || wide_address_select; // [R1] [R2]
              next_s.nib  = next_s.wide ? `QIRC_NIB_WIDE : `QIRC_NIB_NARROW;
              next_s.st   = QD_ADDR;
            end else begin
              next_s.st = QD_IGNORE;
            end
          end
        end
        QD_ADDR: begin
          next_s.addr = {s.addr[27:0], io_q}; // [R3] [R21]
          next_s.cnt  = s.cnt + 4'h1;
          if (s.cnt == s.nib - 4'h1) begin
            next_s.cnt = 4'h0;
            next_s.st  = QD_MODE; // [R16]
          end
        end
        QD_MODE: begin
          next_s.cnt = s.cnt + 4'h1;
          if (s.cnt == 4'h0) begin
            next_s.mode_hi = io_q;
          end
          if (s.cnt == `QIRC_MODE_CYC - 4'h1) begin
            // low mode nibble is never looked at
            next_s.mode_done = 1'b1;
            next_s.pend      = (s.mode_hi == `QIRC_MODE_CONT); // [R12] [R13]
            next_s.ptr       = s.addr[AW-1:0]; // [R10]
            next_s.cnt       = 4'h0;
            next_s.hi        = 1'b1;
            next_s.st        = (dum == 4'h0) ? QD_DATA : QD_DUMMY;
          end
        end
        QD_DUMMY: begin
          // line values are don't-care here, even when floating
          next_s.cnt = s.cnt + 4'h1; // [R6]
          if (s.cnt == dum - 4'h1) begin
            next_s.cnt = 4'h0;
            next_s.st  = QD_DATA;
          end
        end
        default: begin
          next_s.st = s.st;
        end
      endcase
    end else if (sck_f && s.st == QD_DATA) begin
      next_s.io_oe = 1'b1; // [R9]
      if (s.hi) begin
        next_s.io_o = rd_byte[7:4];
        next_s.hi   = 1'b0;
      end else begin
        next_s.io_o = rd_byte[3:0];
        next_s.hi   = 1'b1;
        // pointer width equals the array, so the top rolls to zero
        next_s.ptr  = s.ptr + 1'b1; // [R10] [R11]
      end
    end
  end

  // --------------------------------------------------------------
  // state and array
  // --------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{st: QD_IDLE, default: '0};
    end else if (ce) begin
      s <= next_s;
    end
  end

  // array load port has no reset: contents are data, not control
  always_ff @(posedge clock) begin
    if (ce && load_we) begin
      mem[load_addr] <= load_data;
    end
  end

  assign phase        = s.st;
  assign cont_mode    = s.cont;
  assign link.d_io_o  = s.io_o;
  assign link.d_io_oe = {4{s.io_oe}};
endmodule

/* qirc_host.sv */
// controller end: issues quad i/o reads on apb orders
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "qirc_params.svh"
module qirc_host #(
  parameter int HALF = 10
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               ce,
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output qirc_pkg::qirc_host_st_t link_state,
  qirc_if.host                    link
);
  import qirc_pkg::*;

  // sck never faster than the read allows
  localparam int HALF_EFF = (HALF < `QIRC_HALF_MIN) ? `QIRC_HALF_MIN : HALF; // [R5]

  typedef struct packed {
    qirc_host_st_t st;
    logic          go;
    logic [7:0]    div;
    logic          sck;
    logic          csn;
    logic [16:0]   cnt;
    logic [39:0]   sh;
    logic [3:0]    rx;
    logic          op_wide;
    logic          ext;
    logic          skip;
    logic [31:0]   addr;
    logic [7:0]    mode;
    logic [3:0]    dummy;
    logic [15:0]   count;
    logic [7:0]    data;
    logic          dnew;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic [3:0]    io_o;
    logic [3:0]    io_oe;
  } qirc_host_s_t;

  qirc_host_s_t s;
  qirc_host_s_t next_s;
  logic [3:0]   io_q;

  qirc_sync #(
    .W   (4),
    .RST (4'hf)
  ) u_io (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       (link.io),
    .q       (io_q),
    .rise    (),
    .fall    ()
  );

  always_comb begin
    logic [3:0]  nib;
    logic [31:0] al;
    nib    = (s.op_wide || s.ext) ? `QIRC_NIB_WIDE : `QIRC_NIB_NARROW; // [R1] [R2]
    al     = (s.op_wide || s.ext) ? s.addr : {s.addr[23:0], 8'h00};
    next_s = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    // --------------------------------------------------------------
    // apb slave, one wait state
    // --------------------------------------------------------------
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0;
      case (paddr)
        `QIRC_REG_CTRL: begin
          if (pwrite) begin
            next_s.op_wide = pwdata[`QIRC_CTRL_WIDE_OP];
            next_s.ext     = pwdata[`QIRC_CTRL_EXT];
            next_s.skip    = pwdata[`QIRC_CTRL_SKIP];
            next_s.go      = pwdata[`QIRC_CTRL_START] && s.st == QH_IDLE;
          end
          next_s.prdata[`QIRC_CTRL_WIDE_OP] = s.op_wide;
          next_s.prdata[`QIRC_CTRL_EXT]     = s.ext;
          next_s.prdata[`QIRC_CTRL_SKIP]    = s.skip;
          next_s.prdata[`QIRC_CTRL_BUSY]    = s.st != QH_IDLE || s.go;
        end
        `QIRC_REG_ADDR: begin
          if (pwrite) begin
            next_s.addr = pwdata;
          end
          next_s.prdata = s.addr;
        end
        `QIRC_REG_CFG: begin
          if (pwrite) begin
            next_s.mode  = pwdata[7:0];
            next_s.dummy = pwdata[`QIRC_CFG_DUMMY_LSB +: 4];
            next_s.count = pwdata[`QIRC_CFG_COUNT_LSB +: 16];
          end
          next_s.prdata[7:0]                       = s.mode;
          next_s.prdata[`QIRC_CFG_DUMMY_LSB +: 4]  = s.dummy;
          next_s.prdata[`QIRC_CFG_COUNT_LSB +: 16] = s.count;
        end
        `QIRC_REG_DATA: begin
          next_s.prdata[7:0]            = s.data;
          next_s.prdata[`QIRC_DATA_NEW] = s.dnew;
          if (!pwrite) begin
            next_s.dnew = 1'b0;
          end
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    // --------------------------------------------------------------
    // link sequencer; placed after the read so a new byte wins
    // --------------------------------------------------------------
    if (s.go) begin
      next_s.go  = 1'b0;
      next_s.csn = 1'b0;
      next_s.sck = 1'b0;
      next_s.div = 8'h0;
      next_s.cnt = 17'h0;
      next_s.sh  = s.skip ? {al, 8'h00} : {s.op_wide ? `QIRC_OP_QUAD_WIDE : `QIRC_OP_QUAD, al};
      next_s.st  = s.skip ? QH_ADDR : QH_CMD; // [R13]
    end else if (s.st != QH_IDLE) begin
      if (s.div == 8'(HALF_EFF - 1)) begin
        next_s.div = 8'h0;
        if (!s.sck) begin
          if (s.st == QH_END) begin
            next_s.st = QH_IDLE;
          end else begin
            next_s.sck = 1'b1;
          end
          if (s.st == QH_DATA) begin
            next_s.rx = io_q;
            if (s.cnt[0]) begin
              next_s.data = {s.rx, io_q};
              next_s.dnew = 1'b1;
            end
          end
        end else begin
          next_s.sck = 1'b0;
          next_s.cnt = s.cnt + 17'h1;
          case (s.st)
            QH_CMD: begin
              next_s.sh = {s.sh[38:0], 1'b0}; // [R20]
              if (s.cnt == 17'(`QIRC_OP_BITS - 4'h1)) begin
                next_s.cnt = 17'h0;
                next_s.st  = QH_ADDR;
              end
            end
            QH_ADDR: begin
              next_s.sh = {s.sh[35:0], 4'h0}; // [R3]
              if (s.cnt == 17'(nib - 4'h1)) begin
                next_s.cnt = 17'h0;
                next_s.st  = QH_MODE; // [R16]
              end
            end
            QH_MODE: begin
              if (s.cnt == 17'(`QIRC_MODE_CYC - 4'h1)) begin
                next_s.cnt = 17'h0;
                next_s.st  = (s.dummy == 4'h0) ? QH_DATA : QH_DUMMY;
              end
            end
            QH_DUMMY: begin
              if (s.cnt == 17'(s.dummy - 4'h1)) begin
                next_s.cnt = 17'h0;
                next_s.st  = QH_DATA;
              end
            end
            QH_DATA: begin
              // cs only rises after whole bytes, never in mode or dummy
              // byte k is complete at the rising after count value 2k-1
              if (s.cnt == {s.count, 1'b1}) begin // [R19]
                next_s.csn = 1'b1;
                next_s.st  = QH_END;
              end
            end
            default: begin
              next_s.st = s.st;
            end
          endcase
        end
      end else begin
        next_s.div = s.div + 8'h1;
      end
    end
    // drivers follow the phase about to begin
    case (next_s.st)
      QH_CMD: begin
        next_s.io_o  = {3'h0, next_s.sh[39]};
        next_s.io_oe = 4'h1;
      end
      QH_ADDR: begin
        next_s.io_o  = next_s.sh[39:36];
        next_s.io_oe = 4'hf;
      end
      QH_MODE: begin
        // low mode nibble is ignored, so let go early
        next_s.io_o  = s.mode[7:4];
        next_s.io_oe = (next_s.cnt == 17'h0) ? 4'hf : 4'h0; // [R18] [R17]
      end
      default: begin
        next_s.io_o  = 4'h0;
        next_s.io_oe = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{st: QH_IDLE, csn: 1'b1, mode: 8'ha0, default: '0};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata       = s.prdata;
  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign link_state   = s.st;
  assign link.cs_n    = s.csn;
  assign link.sck     = s.sck;
  assign link.h_io_o  = s.io_o;
  assign link.h_io_oe = s.io_oe;
endmodule

/* qirc_if.sv */
// link between the serial flash read end and its controller
`timescale 1ns/10ps
interface qirc_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  // undriven lines float high, as with a weak pull-up
  assign io = (d_io_oe & d_io_o) | (~d_io_oe & h_io_oe & h_io_o) | (~d_io_oe & ~h_io_oe);

  modport host (output cs_n, output sck, output h_io_o, output h_io_oe, input io);
  modport dev  (input cs_n, input sck, input io, output d_io_o, output d_io_oe);
endinterface

/* qirc_link_asserts.sv */
// concurrent checks on the quad i/o read link between controller and flash end
`timescale 1ns/10ps
module qirc_link_asserts (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] h_io_o,
  input  wire logic [3:0] h_io_oe,
  input  wire logic [3:0] d_io_o,
  input  wire logic [3:0] d_io_oe,
  input  wire logic [3:0] io
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------
  // frame steps
  // --------------------------------------------------------------
  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  sequence s_dev_off;
    ##[1:8] (d_io_oe == 4'h0);
  endsequence
  sequence s_dev_turn;
    $rose(d_io_oe[0]);
  endsequence

  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("sck not low while deselected");
  a_sck_half_min: assert property ($changed(sck) |=> $stable(sck) [*8])
    else $error("sck half period too short");
  a_no_contention: assert property (!(|(d_io_oe & h_io_oe)))
    else $error("both ends drive the data lines");
  a_dev_oe_whole: assert property (d_io_oe == 4'h0 || d_io_oe == 4'hf)
    else $error("device drives only part of the nibble");
  a_io_follows_dev: assert property (d_io_oe == 4'hf |-> io == d_io_o)
    else $error("data lines differ from device nibble");
  a_dev_release: assert property (s_frame_end |-> s_dev_off)
    else $error("device still drives after frame end");
  a_dev_quiet_idle: assert property (cs_n && $past(cs_n, 8) |-> d_io_oe == 4'h0)
    else $error("device drives while deselected");
  a_data_on_fall: assert property (d_io_oe[0] && $past(d_io_oe[0]) && $changed(d_io_o)
    |-> !sck && $past(sck, 6))
    else $error("device data changed away from sck falling");
  a_host_early_off: assert property (s_dev_turn |-> h_io_oe == 4'h0 && $past(h_io_oe, 8) == 4'h0)
    else $error("host still drove just before device turn");
  a_start_lines: assert property ($fell(cs_n) |-> ##[0:9] (h_io_oe == 4'h1 || h_io_oe == 4'hf))
    else $error("host line enables wrong at frame start");
endmodule

/* qirc_params.svh */
// constants shared by both ends of the quad i/o continuous read link
`ifndef QIRC_PARAMS_SVH
`define QIRC_PARAMS_SVH

// opcodes, mode pattern and phase lengths
`define QIRC_OP_QUAD       8'heb
`define QIRC_OP_QUAD_WIDE  8'hec
`define QIRC_MODE_CONT     4'ha
`define QIRC_OP_BITS       4'h8
`define QIRC_NIB_NARROW    4'h6
`define QIRC_NIB_WIDE      4'h8
`define QIRC_MODE_CYC      4'h2

// config_reg_one layout
`define QIRC_QE_BIT        1
`define QIRC_LC_LSB        6

// dummy cycles per latency_code, same for both latency tables
`define QIRC_DUMMY_LC0     4'h4
`define QIRC_DUMMY_LC1     4'h5
`define QIRC_DUMMY_LC2     4'h6
`define QIRC_DUMMY_LC3     4'h1

// clock figures
`define QIRC_CLK_MHZ       200
`define QIRC_SCK_MAX_MHZ   104
`define QIRC_HALF_MIN      ((`QIRC_CLK_MHZ + 2 * `QIRC_SCK_MAX_MHZ - 1) / (2 * `QIRC_SCK_MAX_MHZ))

// controller register map
`define QIRC_REG_CTRL      8'h00
`define QIRC_REG_ADDR      8'h04
`define QIRC_REG_CFG       8'h08
`define QIRC_REG_DATA      8'h0c
`define QIRC_CTRL_START    0
`define QIRC_CTRL_WIDE_OP  1
`define QIRC_CTRL_EXT      2
`define QIRC_CTRL_SKIP     3
`define QIRC_CTRL_BUSY     8
`define QIRC_CFG_DUMMY_LSB 8
`define QIRC_CFG_COUNT_LSB 16
`define QIRC_DATA_NEW      8

`endif

/* qirc_pkg.sv */
// types shared by both ends of the quad i/o continuous read link
package qirc_pkg;

  typedef enum logic [2:0] {
    QD_IDLE,
    QD_OPC,
    QD_ADDR,
    QD_MODE,
    QD_DUMMY,
    QD_DATA,
    QD_IGNORE
  } qirc_dev_st_t;

  typedef enum logic [2:0] {
    QH_IDLE,
    QH_CMD,
    QH_ADDR,
    QH_MODE,
    QH_DUMMY,
    QH_DATA,
    QH_END
  } qirc_host_st_t;

endpackage

/* qirc_sync.sv */
// three-stage input synchroniser with agreed level and edge pulses
`timescale 1ns/10ps
module qirc_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } qirc_sync_s_t;

  qirc_sync_s_t s;
  qirc_sync_s_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // a level counts only once stages two and three agree
    next_s.q    = (s.s2 == s.s3) ? s.s2 : s.q;
    next_s.rise = next_s.q & ~s.q;
    next_s.fall = ~next_s.q & s.q;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{s1: RST, s2: RST, s3: RST, q: RST, rise: '0, fall: '0};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign q    = s.q;
  assign rise = s.rise;
  assign fall = s.fall;
endmodule

/* quad_io_read_continuous_tb.sv */
// self-checking bench for the quad i/o continuous read link
`timescale 1ns/10ps
`include "qirc_params.svh"
module quad_io_read_continuous_tb;
  import qirc_pkg::*;
  logic          clock = 1'b0;
  logic          sys_rst = 1'b1;
  logic [7:0]    paddr = 8'h00;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [7:0]    cfg1 = 8'h02;
  logic          wsel = 1'b0;
  logic          load_we = 1'b0;
  logic [9:0]    load_addr = 10'h0;
  logic [7:0]    load_data = 8'h0;
  qirc_host_st_t hst;
  qirc_dev_st_t  ph;
  logic          cont;
  logic [7:0]    mem [1024];
  int            fails = 0;
  int            n_tests = 0;
  int            cyc = 0;

  always #2.5 clock = ~clock;

  qirc_if lk ();
  qirc_host #(.HALF(10)) i_qirc_host (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_state(hst), .link(lk));
  qirc_dev #(.AW(10)) i_qirc_dev (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .config_reg_one(cfg1),
    .wide_address_select(wsel), .load_we(load_we), .load_addr(load_addr), .load_data(load_data),
    .phase(ph), .cont_mode(cont), .link(lk));
  qirc_link_asserts i_qirc_link_asserts (.clock(clock), .sys_rst(sys_rst), .cs_n(lk.cs_n),
    .sck(lk.sck), .h_io_o(lk.h_io_o), .h_io_oe(lk.h_io_oe), .d_io_o(lk.d_io_o),
    .d_io_oe(lk.d_io_oe), .io(lk.io));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  function automatic logic [3:0] dummy(input logic [1:0] lc);
    dummy = lc == 2'h0 ? `QIRC_DUMMY_LC0 : lc == 2'h1 ? `QIRC_DUMMY_LC1 :
            lc == 2'h2 ? `QIRC_DUMMY_LC2 : `QIRC_DUMMY_LC3;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no cycle count assumed: only the bench timeout ends a hung access
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one read frame ordered over apb; bytes and continuous flag compared
  task automatic rd(input logic [3:0] ctl, input logic [31:0] a, input int n, input logic [7:0] md,
                    input logic [1:0] lc, input logic qe);
    logic [31:0] r;
    logic        e;
    int          k;
    cfg1 <= {lc, 4'h0, qe, 1'b0};
    wsel <= ctl[2];
    apb(1'b1, `QIRC_REG_CFG, {16'(n - 1), 4'h0, dummy(lc), md}, r, e);
    apb(1'b1, `QIRC_REG_ADDR, a, r, e);
    apb(1'b1, `QIRC_REG_CTRL, {28'h0, ctl | 4'h1}, r, e);
    apb(1'b0, `QIRC_REG_CTRL, 32'h0, r, e);
    chk("busy", 32'h1, {31'h0, r[`QIRC_CTRL_BUSY]});
    for (int i = 0; i < n; i++) begin
      // first byte may take several hundred clocks; the bench timeout guards a hang
      do begin
        apb(1'b0, `QIRC_REG_DATA, 32'h0, r, e);
      end while (r[`QIRC_DATA_NEW] !== 1'b1);
      chk("byte", {24'h0, qe ? mem[10'(a + i)] : 8'hff}, {24'h0, r[7:0]});
    end
    k = 0;
    while ((hst !== QH_IDLE || ph !== QD_IDLE) && k < 400) begin
      @(posedge clock);
      k++;
    end
    chk("cont", {31'h0, qe && md[7:4] == `QIRC_MODE_CONT}, {31'h0, cont});
  endtask

  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fails++;
      test_done;
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    void'($urandom(32'h0aef6d5b));
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    // synchronisers settle before the first frame
    repeat (6) @(posedge clock);
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'($urandom % 255);
      load_we <= 1'b1;
      load_addr <= 10'(i);
      load_data <= mem[i];
      @(posedge clock);
    end
    load_we <= 1'b0;
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b0, `QIRC_REG_CFG, 32'h0, r, e);
    chk("cfg mode reset", 32'h000000a0, {24'h0, r[7:0]});
    for (int lc = 0; lc < 4; lc++) rd(4'h0, $urandom, 3, 8'h0f, 2'(lc), 1'b1);
    rd(4'h4, 32'h000003fe, 4, 8'h5a, 2'h0, 1'b1);
    rd(4'h2, $urandom, 2, 8'ha5, 2'h2, 1'b1);
    rd(4'ha, $urandom, 2, 8'h3a, 2'h1, 1'b1);
    rd(4'h0, $urandom, 1, 8'haf, 2'h3, 1'b1);
    rd(4'h8, $urandom, 2, 8'ha0, 2'h0, 1'b1);
    rd(4'h8, $urandom, 1, 8'h7a, 2'h0, 1'b1);
    rd(4'h0, $urandom, 1, 8'ha0, 2'h0, 1'b0);
    test_done;
  end
endmodule
